// ---- src/dpt_pkg.sv ----
// package: register map, field positions and reset values of the output protect block
package dpt_pkg;
  localparam int ADDR_W = 9;
  localparam int DATA_W = 8;
  localparam int TCODE_W = 16;
  localparam logic [ADDR_W-1:0] SEQ_CTRL_ADDR   = 9'h11F;
  localparam logic [ADDR_W-1:0] OUT_CTRL_ADDR   = 9'h125;
  localparam logic [ADDR_W-1:0] AUTO_OFF_ADDR   = 9'h12C;
  localparam logic [ADDR_W-1:0] TEMP_CTRL_ADDR  = 9'h12F;
  localparam logic [ADDR_W-1:0] TCODE_LO_ADDR   = 9'h132;
  localparam logic [ADDR_W-1:0] TCODE_HI_ADDR   = 9'h133;
  localparam logic [ADDR_W-1:0] TREFRESH_ADDR   = 9'h134;
  localparam logic [ADDR_W-1:0] OFFSET_CTRL_ADDR = 9'h135;
  localparam logic [ADDR_W-1:0] IRQ_STAT_ADDR   = 9'h150;
  localparam logic [ADDR_W-1:0] IRQ_MASK_ADDR   = 9'h151;
  localparam logic [ADDR_W-1:0] OUT_STAT_ADDR   = 9'h152;
  localparam logic [DATA_W-1:0] SEQ_CTRL_RST    = 8'h83;
  localparam logic [DATA_W-1:0] AUTO_OFF_RST    = 8'h81;
  localparam logic [DATA_W-1:0] TEMP_CTRL_RST   = 8'h20;
  localparam logic [DATA_W-1:0] ZERO_RST        = 8'h00;
  localparam int SEQ_ON_BIT     = 0;
  localparam int POL_INV_BIT    = 2;
  localparam int FALL_CNT_LSB   = 6;
  localparam int RISE_CNT_LSB   = 4;
  localparam int MAN_ON_BIT     = 0;
  localparam int MAN_OFF_BIT    = 1;
  localparam int AVG_CUT_BIT    = 0;
  localparam int PROT_MODE_BIT  = 7;
  localparam int SENS_EN_BIT    = 0;
  localparam int REFRESH_BIT    = 0;
  localparam int OFFSET_ON_BIT  = 0;
  localparam int EV_SHUTDOWN    = 0;
  localparam int EV_POWER_ON    = 1;
  localparam int EV_TCODE       = 2;
  localparam int N_EV           = 3;
  // per-stage delay of the protect sequencer, in ns, and its cycle count at 25 MHz
  localparam int STAGE_NS       = 1000;
  localparam int CLK_NS         = 40;
  localparam int STAGE_CYC      = (STAGE_NS + CLK_NS - 1) / CLK_NS;
  localparam int CNT_W          = 8;
  // sensor conversion latency, cycles
  localparam int CONV_CYC       = 16;
  typedef enum logic [1:0] {
    DPT_SEQ_IDLE = 2'b00,
    DPT_SEQ_RISE = 2'b01,
    DPT_SEQ_ON   = 2'b10,
    DPT_SEQ_FALL = 2'b11
  } dpt_seq_t;
endpackage

// ---- src/dpt_tsense_if.sv ----
// interface: request and result between control and temperature sensor front end
`timescale 1ns/10ps
interface dpt_tsense_if;
  logic        enable;
  logic        start;
  logic        done;
  logic [15:0] code;
  modport ctrl (output enable, output start, input done, input code);
  modport sens (input enable, input start, output done, output code);
endinterface

// ---- src/dpt_tsense.sv ----
// module: temperature sensor front end, samples the die code on request
`timescale 1ns/10ps
module dpt_tsense (
  input  wire logic          ref_clk_i,
  input  wire logic          rst_i,
  input  wire logic [15:0]   die_code_i,
  dpt_tsense_if.sens         ts
);
  import dpt_pkg::*;
  logic [15:0] sync0;
  logic [15:0] sync1;
  logic [7:0]  busy_cnt;
  logic        done;
  logic [15:0] code;
  // ****************************************
  // conversion timing
  // ****************************************
  always_ff @(posedge ref_clk_i) begin
    sync0 <= die_code_i;
    sync1 <= sync0;
  end
  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      busy_cnt <= 8'h00;
      done     <= 1'b0;
      code     <= 16'h0000;
    end else begin
      done <= 1'b0;
      if (ts.start && ts.enable && busy_cnt == 8'h00) begin
        busy_cnt <= 8'(CONV_CYC);
      end else if (busy_cnt == 8'h01) begin
        busy_cnt <= 8'h00;
        done     <= 1'b1;
        code     <= sync1;
      end else if (busy_cnt != 8'h00) begin
        busy_cnt <= busy_cnt - 8'h01;
      end
    end
  end
  assign ts.done = done;
  assign ts.code = code;
endmodule // dpt_tsense

// ---- src/dpt_top.sv ----
// module: output protect, shutdown control and temperature readback register bank
`timescale 1ns/10ps
module dpt_top (
  input  wire logic                         ref_clk_i,
  input  wire logic                         rst_i,
  input  wire logic [dpt_pkg::ADDR_W-1:0]   addr_i,
  input  wire logic [dpt_pkg::DATA_W-1:0]   wdata_i,
  input  wire logic                         wr_i,
  input  wire logic                         rd_i,
  output logic      [dpt_pkg::DATA_W-1:0]   rdata_o,
  input  wire logic                         tx_gate_pin_i,
  input  wire logic                         fault_i,
  input  wire logic                         avg_power_over_i,
  input  wire logic [dpt_pkg::TCODE_W-1:0]  die_code_i,
  output logic                              protect_o,
  output logic                              output_on_o,
  output logic                              sensor_on_o,
  output logic                              offset_on_o,
  output logic                              irq_o
);
  import dpt_pkg::*;

  // ****************************************
  // registers
  // ****************************************
  logic [DATA_W-1:0]  seq_ctrl;
  logic               manual_output_off;
  logic               manual_output_on_pulse;
  logic [DATA_W-1:0]  auto_off;
  logic [DATA_W-1:0]  temp_ctrl;
  logic               refresh_bit;
  logic               refresh_prev;
  logic               offset_on;
  logic [TCODE_W-1:0] tcode;
  logic [N_EV-1:0]    irq_stat;
  logic [N_EV-1:0]    irq_mask;
  logic               out_on;
  logic               protect_active;
  dpt_seq_t           seq_state;
  logic [CNT_W-1:0]   stage_cnt;
  logic [1:0]         stages_left;
  logic [2:0]         gate_sync;
  logic [1:0]         fault_sync;
  logic [1:0]         avg_sync;
  dpt_seq_t           next_seq_state;
  logic [CNT_W-1:0]   next_stage_cnt;
  logic [1:0]         next_stages_left;
  logic               next_protect_active;

  // ****************************************
  // decode
  // ****************************************
  function automatic logic reg_hit(input logic              strobe,
                                   input logic [ADDR_W-1:0] a,
                                   input logic [ADDR_W-1:0] target);
    return strobe && a == target;
  endfunction

  wire wr_seq     = reg_hit(wr_i, addr_i, SEQ_CTRL_ADDR);
  wire wr_out     = reg_hit(wr_i, addr_i, OUT_CTRL_ADDR);
  wire wr_auto    = reg_hit(wr_i, addr_i, AUTO_OFF_ADDR);
  wire wr_temp    = reg_hit(wr_i, addr_i, TEMP_CTRL_ADDR);
  wire wr_refresh = reg_hit(wr_i, addr_i, TREFRESH_ADDR);
  wire wr_offset  = reg_hit(wr_i, addr_i, OFFSET_CTRL_ADDR);
  wire wr_istat   = reg_hit(wr_i, addr_i, IRQ_STAT_ADDR);
  wire wr_imask   = reg_hit(wr_i, addr_i, IRQ_MASK_ADDR);

  wire gate_pin   = gate_sync[2];
  wire gate_prev  = gate_sync[1] ^ 1'b0;
  wire sequencer_on  = seq_ctrl[SEQ_ON_BIT];
  wire pol_invert    = seq_ctrl[POL_INV_BIT];
  wire [1:0] fall_n  = seq_ctrl[FALL_CNT_LSB +: 2];
  wire [1:0] rise_n  = seq_ctrl[RISE_CNT_LSB +: 2];
  wire protect_mode  = auto_off[PROT_MODE_BIT];
  wire avg_cut_on    = auto_off[AVG_CUT_BIT];
  wire fault_err     = protect_mode && fault_sync[1];
  wire power_err     = protect_mode && avg_cut_on && avg_sync[1];
  wire auto_off_evt  = fault_err || power_err;
  wire man_on_eff    = manual_output_on_pulse && !manual_output_off;
  wire next_out_on   = manual_output_off ? 1'b0 :
                       auto_off_evt      ? 1'b0 :
                       man_on_eff        ? 1'b1 : out_on;
  wire refresh_rise  = refresh_bit && !refresh_prev;
  wire error_level   = !protect_active || !out_on;
  wire next_protect  = pol_invert ? error_level : !error_level;

  wire [N_EV-1:0] ev;
  assign ev[EV_SHUTDOWN] = out_on && !next_out_on;
  assign ev[EV_POWER_ON] = !out_on && next_out_on;
  wire tcode_done;
  assign ev[EV_TCODE]    = tcode_done;

  // ****************************************
  // temperature sensor
  // ****************************************
  dpt_tsense_if ts ();
  assign ts.enable = temp_ctrl[SENS_EN_BIT];
  assign ts.start  = refresh_rise;
  assign tcode_done = ts.done;

  dpt_tsense u_tsense (
    .ref_clk_i  (ref_clk_i),
    .rst_i      (rst_i),
    .die_code_i (die_code_i),
    .ts         (ts.sens)
  );

  // ****************************************
  // input synchronisers
  // ****************************************
  always_ff @(posedge ref_clk_i) begin
    gate_sync <= {gate_sync[1:0], tx_gate_pin_i};
  end

  always_ff @(posedge ref_clk_i) begin
    fault_sync <= {fault_sync[0], fault_i};
  end

  always_ff @(posedge ref_clk_i) begin
    avg_sync <= {avg_sync[0], avg_power_over_i};
  end

  // ****************************************
  // register writes
  // ****************************************
  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      seq_ctrl <= SEQ_CTRL_RST;
    end else if (wr_seq) begin
      seq_ctrl <= wdata_i;
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      auto_off <= AUTO_OFF_RST;
    end else if (wr_auto) begin
      auto_off <= wdata_i;
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      temp_ctrl <= TEMP_CTRL_RST;
    end else if (wr_temp) begin
      temp_ctrl <= wdata_i;
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      offset_on <= 1'b0;
    end else if (wr_offset) begin
      offset_on <= wdata_i[OFFSET_ON_BIT];
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      irq_mask <= '0;
    end else if (wr_imask) begin
      irq_mask <= wdata_i[N_EV-1:0];
    end
  end

  // manual control bits, the on pulse clears itself the cycle after
  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      out_on <= 1'b1;
    end else begin
      out_on <= next_out_on;
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      manual_output_on_pulse <= 1'b0;
    end else begin
      manual_output_on_pulse <= wr_out ? wdata_i[MAN_ON_BIT] : 1'b0;
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      manual_output_off <= 1'b0;
    end else if (wr_out) begin
      manual_output_off <= wdata_i[MAN_OFF_BIT];
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      refresh_bit  <= 1'b0;
      refresh_prev <= 1'b0;
    end else begin
      refresh_prev <= refresh_bit;
      if (wr_refresh) refresh_bit <= wdata_i[REFRESH_BIT];
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      tcode <= '0;
    end else if (ts.done) begin
      tcode <= ts.code;
    end
  end

  // sticky status, set beats write-one clear
  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      irq_stat <= '0;
    end else begin
      irq_stat <= (irq_stat & ~(wr_istat ? wdata_i[N_EV-1:0] : '0)) | ev;
    end
  end

  // ****************************************
  // transmit gate sequencer
  // ****************************************
  function automatic logic stage_end(input logic [CNT_W-1:0] cnt);
    return cnt == CNT_W'(STAGE_CYC - 1);
  endfunction

  function automatic logic [CNT_W-1:0] stage_step(input logic [CNT_W-1:0] cnt);
    return stage_end(cnt) ? '0 : cnt + CNT_W'(1);
  endfunction

  function automatic logic [1:0] stages_step(input logic [1:0] left, input logic [CNT_W-1:0] cnt);
    return stage_end(cnt) ? left - 2'b01 : left;
  endfunction

  always_comb begin
    next_seq_state      = seq_state;
    next_stage_cnt      = stage_cnt;
    next_stages_left    = stages_left;
    next_protect_active = protect_active;
    if (!sequencer_on) begin
      next_seq_state      = DPT_SEQ_IDLE;
      next_stage_cnt      = '0;
      next_protect_active = gate_pin;
    end else begin
      unique case (seq_state)
        DPT_SEQ_IDLE: begin
          next_protect_active = 1'b0;
          if (gate_pin) begin
            next_stage_cnt   = '0;
            next_stages_left = rise_n;
            next_seq_state   = DPT_SEQ_RISE;
          end
        end
        DPT_SEQ_RISE: begin
          if (!gate_pin) begin
            next_seq_state = DPT_SEQ_IDLE;
          end else if (stages_left == 2'b00) begin
            next_protect_active = 1'b1;
            next_seq_state      = DPT_SEQ_ON;
          end else begin
            next_stage_cnt   = stage_step(stage_cnt);
            next_stages_left = stages_step(stages_left, stage_cnt);
          end
        end
        DPT_SEQ_ON: begin
          if (!gate_pin && gate_prev == 1'b0) begin
            next_stage_cnt   = '0;
            next_stages_left = fall_n;
            next_seq_state   = DPT_SEQ_FALL;
          end
        end
        DPT_SEQ_FALL: begin
          if (gate_pin) begin
            next_seq_state = DPT_SEQ_ON;
          end else if (stages_left == 2'b00) begin
            next_protect_active = 1'b0;
            next_seq_state      = DPT_SEQ_IDLE;
          end else begin
            next_stage_cnt   = stage_step(stage_cnt);
            next_stages_left = stages_step(stages_left, stage_cnt);
          end
        end
      endcase
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      seq_state      <= DPT_SEQ_IDLE;
      stage_cnt      <= '0;
      stages_left    <= 2'b00;
      protect_active <= 1'b0;
    end else begin
      seq_state      <= next_seq_state;
      stage_cnt      <= next_stage_cnt;
      stages_left    <= next_stages_left;
      protect_active <= next_protect_active;
    end
  end

  // ****************************************
  // read data and outputs
  // ****************************************
  logic [DATA_W-1:0] rsel;
  always_comb begin
    unique case (addr_i)
      SEQ_CTRL_ADDR:    rsel = seq_ctrl;
      OUT_CTRL_ADDR:    rsel = {6'h00, manual_output_off, 1'b0};
      AUTO_OFF_ADDR:    rsel = auto_off;
      TEMP_CTRL_ADDR:   rsel = temp_ctrl;
      TCODE_LO_ADDR:    rsel = tcode[7:0];
      TCODE_HI_ADDR:    rsel = tcode[15:8];
      TREFRESH_ADDR:    rsel = {7'h00, refresh_bit};
      OFFSET_CTRL_ADDR: rsel = {7'h00, offset_on};
      IRQ_STAT_ADDR:    rsel = {5'h00, irq_stat};
      IRQ_MASK_ADDR:    rsel = {5'h00, irq_mask};
      OUT_STAT_ADDR:    rsel = {6'h00, protect_active, out_on};
      default:          rsel = 8'h00;
    endcase
  end

  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      rdata_o     <= 8'h00;
      protect_o   <= 1'b0;
      output_on_o <= 1'b0;
      sensor_on_o <= 1'b0;
      offset_on_o <= 1'b0;
      irq_o       <= 1'b0;
    end else begin
      rdata_o     <= rd_i ? rsel : 8'h00;
      protect_o   <= next_protect;
      output_on_o <= out_on;
      sensor_on_o <= temp_ctrl[SENS_EN_BIT];
      offset_on_o <= offset_on;
      irq_o       <= |(irq_stat & irq_mask);
    end
  end
endmodule // dpt_top

// ---- tb/dpt_top_chk.sv ----
// checker: port assertions of the output protect register bank
`timescale 1ns/10ps
module dpt_top_chk (
  input  wire logic                       ref_clk_i,
  input  wire logic                       rst_i,
  input  wire logic [dpt_pkg::ADDR_W-1:0] addr_i,
  input  wire logic [dpt_pkg::DATA_W-1:0] wdata_i,
  input  wire logic                       wr_i,
  input  wire logic                       rd_i,
  input  wire logic [dpt_pkg::DATA_W-1:0] rdata_o,
  input  wire logic                       fault_i,
  input  wire logic                       output_on_o,
  input  wire logic                       sensor_on_o,
  input  wire logic                       offset_on_o,
  input  wire logic                       irq_o
);
  import dpt_pkg::*;
  // ****************
  // assertions
  // ****************
  default clocking cb @(posedge ref_clk_i); endclocking
  default disable iff (rst_i);
  wire logic mapped = addr_i inside {SEQ_CTRL_ADDR, OUT_CTRL_ADDR, AUTO_OFF_ADDR, TEMP_CTRL_ADDR, TCODE_LO_ADDR,
                                     TCODE_HI_ADDR, TREFRESH_ADDR, OFFSET_CTRL_ADDR, IRQ_STAT_ADDR, IRQ_MASK_ADDR,
                                     OUT_STAT_ADDR};
  a_rdata_idle_zero: assert property (!$past(rd_i) |-> rdata_o == 8'h00)
    else $error("read data not zero outside read");
  a_unmapped_read: assert property (rd_i && !mapped |=> rdata_o == 8'h00)
    else $error("unmapped read not zero");
  a_manual_off_holds: assert property (wr_i && addr_i == OUT_CTRL_ADDR && wdata_i[MAN_OFF_BIT]
    |-> ##3 (!output_on_o)[*4])
    else $error("output on despite manual off");
  a_pulse_self_clear: assert property (rd_i && addr_i == OUT_CTRL_ADDR |=> rdata_o[MAN_ON_BIT] == 1'b0)
    else $error("turn-on bit reads one");
  a_mask_quiet: assert property (wr_i && addr_i == IRQ_MASK_ADDR && wdata_i == 8'h00 |=> ##1 !irq_o)
    else $error("interrupt with zero mask");
  a_offset_follow: assert property (wr_i && addr_i == OFFSET_CTRL_ADDR
    |-> ##2 offset_on_o == $past(wdata_i[OFFSET_ON_BIT], 2))
    else $error("offset enable does not follow write");
  a_sensor_follow: assert property (wr_i && addr_i == TEMP_CTRL_ADDR
    |-> ##2 sensor_on_o == $past(wdata_i[SENS_EN_BIT], 2))
    else $error("sensor enable does not follow write");
  a_on_after_reset: assert property ($fell(rst_i) && !fault_i |-> ##[1:3] output_on_o)
    else $error("output not on after reset");
  c_tcode_read: cover property (rd_i && addr_i == TCODE_LO_ADDR);
  c_irq: cover property (irq_o);
  c_out_off: cover property (!output_on_o);
endmodule // dpt_top_chk
bind dpt_top dpt_top_chk chk_u (.ref_clk_i(ref_clk_i), .rst_i(rst_i), .addr_i(addr_i), .wdata_i(wdata_i),
  .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .fault_i(fault_i), .output_on_o(output_on_o),
  .sensor_on_o(sensor_on_o), .offset_on_o(offset_on_o), .irq_o(irq_o));

// ---- tb/tb.sv ----
// testbench: register bank, output shutdown and temperature readback
`timescale 1ns/10ps
module tb;
  import dpt_pkg::*;
  logic ref_clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic [8:0] addr_i = '0;
  logic [7:0] wdata_i = '0;
  logic wr_i = 1'b0, rd_i = 1'b0, pin_i = 1'b1, fault_i = 1'b0, avg_i = 1'b0;
  logic [15:0] die_i = '0;
  logic [7:0] rdata_o;
  logic prot_o, on_o, sens_o, offs_o, irq_o;
  int n_errors = 0, checked = 0, mdl[int], k;
  int addrs[$] = '{'h11F, 'h125, 'h12C, 'h12F, 'h132, 'h133, 'h134, 'h135, 'h1FF};
  int rstv[$] = '{'h83, 0, 'h81, 'h20, 0, 0, 0, 0, 0};
  int pcase[$] = '{'h81100, 'h01111, 'h81010, 'h80011};
  int qcase[$] = '{'h8211, 'h8200, 'h8610, 'h8601};
  always #20 ref_clk_i = ~ref_clk_i;
  dpt_top dut_u (.ref_clk_i(ref_clk_i), .rst_i(rst_i), .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i),
    .rd_i(rd_i), .rdata_o(rdata_o), .tx_gate_pin_i(pin_i), .fault_i(fault_i), .avg_power_over_i(avg_i),
    .die_code_i(die_i), .protect_o(prot_o), .output_on_o(on_o), .sensor_on_o(sens_o), .offset_on_o(offs_o),
    .irq_o(irq_o));
  // ****************
  // bus tasks and checks
  // ****************
  task automatic cyc(input int n);
    repeat (n) @(posedge ref_clk_i);
  endtask
  task automatic cmp(input string n, input logic [15:0] e, input logic [15:0] g);
    checked++;
    if (g !== e) begin
      n_errors++;
      $display("unexpected %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic co(input string n, ref logic g, input logic e);
    @(negedge ref_clk_i);
    cmp(n, {15'h0, e}, {15'h0, g});
    @(posedge ref_clk_i);
  endtask
  task automatic wr(input int a, input int d);
    addr_i <= a[8:0]; wdata_i <= d[7:0]; wr_i <= 1'b1;
    @(posedge ref_clk_i);
    wr_i <= 1'b0;
    @(posedge ref_clk_i);
  endtask
  task automatic mw(input int a, input int d);
    wr(a, d);
    if (a == 'h125) mdl[a] = d & 'hFE;
    else if (a != 'h132 && a != 'h133 && mdl.exists(a) && a != 'h1FF) mdl[a] = d;
  endtask
  task automatic rc(input int a);
    int e;
    logic [7:0] d;
    e = mdl[a];
    addr_i <= a[8:0]; rd_i <= 1'b1;
    @(posedge ref_clk_i);
    rd_i <= 1'b0;
    @(negedge ref_clk_i);
    d = rdata_o;
    @(posedge ref_clk_i);
    cmp("rdata_o", {8'h00, e[7:0]}, {8'h00, d});
  endtask
  task automatic end_sim;
    $display("errors %0d checks %0d", n_errors, checked);
    if (n_errors == 0 && checked > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask
  initial begin
    cyc(20000);
    n_errors++;
    end_sim();
  end
  // ****************
  // main sequence
  // ****************
  initial begin
    void'($urandom(32'h2C5983E1));
    cyc(12);
    rst_i <= 1'b0;
    cyc(2);
    foreach (addrs[i]) mdl[addrs[i]] = rstv[i];
    foreach (addrs[i]) rc(addrs[i]);
    co("output_on_o", on_o, 1'b1);
    co("sensor_on_o", sens_o, 1'b0);
    k = $urandom_range(1, 0);
    mw('h135, k);
    rc('h135);
    co("offset_on_o", offs_o, k[0]);
    mw('h132, 'hA5);
    mw('h1FF, 'h5A);
    rc('h132);
    rc('h1FF);
    wr('h151, 'h07);
    mw('h125, 'h02);
    mw('h125, 'h03);
    cyc(4);
    co("output_on_o", on_o, 1'b0);
    rc('h125);
    co("irq_o", irq_o, 1'b1);
    mw('h125, 'h00);
    mw('h125, 'h01);
    cyc(4);
    co("output_on_o", on_o, 1'b1);
    rc('h125);
    wr('h150, 'hFF);
    wr('h151, 'h00);
    co("irq_o", irq_o, 1'b0);
    foreach (pcase[i]) begin
      mw('h12C, pcase[i][19:12]);
      fault_i <= pcase[i][8]; avg_i <= pcase[i][4];
      cyc(8);
      co("output_on_o", on_o, pcase[i][0]);
      fault_i <= 1'b0; avg_i <= 1'b0;
      cyc(8);
      mw('h125, 'h01);
      cyc(4);
    end
    mw('h12C, 'h81);
    foreach (qcase[i]) begin
      mw('h11F, qcase[i][15:8]);
      pin_i <= qcase[i][4];
      cyc(8);
      co("protect_o", prot_o, qcase[i][0]);
    end
    mw('h11F, 'h83);
    pin_i <= 1'b1;
    cyc(8);
    co("protect_o", prot_o, 1'b1);
    pin_i <= 1'b0;
    cyc(2 * STAGE_CYC - 4);
    co("protect_o", prot_o, 1'b1);
    cyc(12);
    co("protect_o", prot_o, 1'b0);
    mw('h12F, 'h21);
    co("sensor_on_o", sens_o, 1'b1);
    wr('h151, 'h04);
    repeat (2) begin
      die_i <= 16'($urandom);
      cyc(4);
      mw('h134, 0);
      mw('h134, 1);
      for (k = 0; k < 200 && irq_o !== 1'b1; k++) @(posedge ref_clk_i);
      co("irq_o", irq_o, 1'b1);
      mdl['h132] = die_i[7:0];
      mdl['h133] = die_i[15:8];
      rc('h132);
      rc('h133);
      wr('h150, 'h04);
      die_i <= ~die_i;
      cyc(40);
      mw('h134, 1);
      cyc(40);
      rc('h132);
      rc('h133);
    end
    end_sim();
  end
endmodule // tb
